/* design/csmaca_pkg.sv */
package csmaca_pkg;

  // Register indices: the offsets are not all multiples of four, so the byte address is four times the index.
  localparam logic [7:0] IDX_ACCESS_CONTROL = 8'h11;
  localparam logic [7:0] IDX_LONG_SPACING = 8'h21;
  localparam logic [7:0] IDX_TURNAROUND = 8'h27;
  localparam logic [7:0] IDX_STAB_SHORT = 8'h2E;
  localparam logic [7:0] IDX_COMMAND = 8'h40;
  localparam logic [7:0] IDX_STATUS = 8'h41;
  localparam logic [7:0] IDX_TIMING = 8'h42;
  localparam logic [7:0] IDX_RANDOM = 8'h43;
  localparam int BYTE_SHIFT = 2;

  // Field positions.
  localparam int F_NO_CSMA = 7;
  localparam int F_BLE = 6;
  localparam int F_SLOTTED = 5;
  localparam int F_MINBE_LO = 3;
  localparam int F_MAXBF_LO = 0;
  localparam int F_LIFS_LO = 2;
  localparam int F_TURN_LO = 4;
  localparam int F_STAB_LO = 4;
  localparam int F_SIFS_LO = 0;

  // Reset values.
  localparam logic [7:0] RST_ACCESS_CONTROL = 8'h1C;
  localparam logic [7:0] RST_LONG_SPACING = 8'h70;
  localparam logic [7:0] RST_TURNAROUND = 8'h30;
  localparam logic [7:0] RST_STAB_SHORT = 8'h98;

  // Frame size limit for the short spacing, in octets.
  localparam logic [6:0] MAX_SHORT_FRAME_OCTETS = 7'h12;
  // Backoff period length in symbols.
  localparam int UNIT_BACKOFF_SYMBOLS = 20;
  // Largest backoff exponent.
  localparam logic [2:0] MAX_BE = 3'h5;
  // Battery life extension caps the exponent.
  localparam logic [2:0] BLE_BE_CAP = 3'h2;
  // Clear channel assessment periods required in slotted mode.
  localparam logic [1:0] SLOTTED_CW = 2'h2;

  typedef enum logic [1:0] {
    CSMACA_RES_NONE,
    CSMACA_RES_SUCCESS,
    CSMACA_RES_FAIL
  } csmaca_result_type;

  typedef enum logic [2:0] {
    CSMACA_ST_IDLE,
    CSMACA_ST_IFS,
    CSMACA_ST_BACKOFF,
    CSMACA_ST_CCA,
    CSMACA_ST_SEND,
    CSMACA_ST_ACKWAIT
  } csmaca_state_type;

endpackage : csmaca_pkg

/* design/csmaca_symbol_timer.sv */
`timescale 1ns/1ps
module csmaca_symbol_timer #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic load,
  input wire logic [WIDTH-1:0] count,
  input wire logic symbol_tick,
  // Status
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] remain_q;
  logic [WIDTH-1:0] remain_d;
  logic busy_d;
  logic done_d;
  wire last_tick = busy && symbol_tick && (remain_q == WIDTH'(1));

  assign remain_d = load ? count : ((busy && symbol_tick) ? remain_q - WIDTH'(1) : remain_q);
  assign busy_d = load ? (count != '0) : (busy && !last_tick);
  assign done_d = (load && count == '0) || (!load && last_tick);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      remain_q <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      remain_q <= remain_d;
      busy <= busy_d;
      done <= done_d;
    end
  end

endmodule : csmaca_symbol_timer

/* design/csmaca_random.sv */
`timescale 1ns/1ps
module csmaca_random (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Seed load and output
  input wire logic seed_load,
  input wire logic [15:0] seed,
  output logic [15:0] value
);

  // Galois shift register; an all-zero seed is replaced so it never locks up.
  logic [15:0] value_d;
  wire [15:0] shifted = {1'b0, value[15:1]} ^ (value[0] ? 16'hB400 : 16'h0000);

  assign value_d = seed_load ? ((seed == 16'h0000) ? 16'h0001 : seed) : shifted;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      value <= 16'hACE1;
    else
      value <= value_d;
  end

endmodule : csmaca_random

/* design/csmaca_ifs_timing.sv */
`timescale 1ns/1ps
// Behaviour
// - Access bit clear selects unslotted CSMA-CA.
// - Access bit set selects slotted CSMA-CA.
// - In slotted mode, battery life extension bit caps the backoff exponent.
// - Minimum backoff exponent is a two-bit field, resetting to 3.
// - Maximum backoff count is a three-bit field 0 to 5, resetting to 4; the code takes any written value 0 to 7.
// - Backoff waiting counts whole backoff periods; spacing waits count symbols.
// - Slotted backoff periods start on coordinator slot boundaries.
// - Unslotted backoff periods run from the device's own timing.
// - Frames up to 18 octets are followed by the short spacing.
// - Longer frames are followed by the long spacing.
// - With an acknowledgment request, spacing starts after the acknowledgment.
// - Short spacing equals short base plus stabilization count.
// - Long spacing equals long base plus stabilization count.
// - Turnaround equals turnaround base plus stabilization count.
module csmaca_ifs_timing (
  // AHB-Lite clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Radio and MAC timing
  input wire logic symbol_tick,
  input wire logic slot_boundary,
  input wire logic cca_clear,
  input wire logic cca_done,
  input wire logic tx_request,
  input wire logic tx_direct,
  input wire logic [6:0] tx_length,
  input wire logic tx_ack_request,
  input wire logic tx_end,
  input wire logic ack_end,
  // Outputs
  output logic cca_start,
  output logic tx_start,
  output logic tx_busy,
  output logic ack_window,
  output logic [1:0] tx_result
);

  localparam logic [7:0] BACKOFF_SYMBOLS = 8'(csmaca_pkg::UNIT_BACKOFF_SYMBOLS);

  // Registers.
  logic [7:0] access_q;
  logic [7:0] long_q;
  logic [7:0] turn_q;
  logic [7:0] stab_q;
  logic [15:0] seed_q;
  csmaca_pkg::csmaca_state_type state_q;
  csmaca_pkg::csmaca_state_type state_d;
  logic [2:0] be_q;
  logic [2:0] nb_q;
  logic [1:0] cw_q;
  logic [5:0] backoff_left_q;
  logic long_ifs_q;
  logic ifs_pending_q;
  logic [2:0] fail_count_q;

  // Bus address phase capture.
  logic wr_pend_q;
  logic [7:0] wr_idx_q;
  logic seed_load_q;

  // Field extraction.
  wire no_csma = access_q[csmaca_pkg::F_NO_CSMA];
  wire slotted = access_q[csmaca_pkg::F_SLOTTED];
  wire ble = access_q[csmaca_pkg::F_BLE] && slotted;
  wire [1:0] min_backoff_exponent = access_q[csmaca_pkg::F_MINBE_LO +: 2];
  wire [2:0] max_backoff_count = access_q[csmaca_pkg::F_MAXBF_LO +: 3];
  wire [5:0] long_spacing_base = long_q[csmaca_pkg::F_LIFS_LO +: 6];
  wire [3:0] turnaround_base = turn_q[csmaca_pkg::F_TURN_LO +: 4];
  wire [3:0] radio_stabilization_count = stab_q[csmaca_pkg::F_STAB_LO +: 4];
  wire [3:0] short_spacing_base = stab_q[csmaca_pkg::F_SIFS_LO +: 4];

  function automatic logic [7:0] add_stab(input logic [5:0] base, input logic [3:0] stab);
    add_stab = 8'(base) + 8'(stab);
  endfunction : add_stab

  wire [7:0] short_ifs_symbols = add_stab(6'(short_spacing_base), radio_stabilization_count);
  wire [7:0] long_ifs_symbols = add_stab(long_spacing_base, radio_stabilization_count);
  wire [7:0] turnaround_symbols = add_stab(6'(turnaround_base), radio_stabilization_count);

  // Timer and random source.
  logic timer_load;
  logic [7:0] timer_count;
  logic timer_busy;
  logic timer_done;
  logic [15:0] rand_value;

  csmaca_symbol_timer #(.WIDTH(8)) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(timer_load),
    .count(timer_count),
    .symbol_tick(symbol_tick),
    .busy(timer_busy),
    .done(timer_done)
  );

  csmaca_random u_random (
    .hclk(hclk),
    .hresetn(hresetn),
    .seed_load(seed_load_q),
    .seed(seed_q),
    .value(rand_value)
  );

  // Backoff draw: random number in 0 .. 2^BE-1 periods.
  wire [2:0] be_start = ble ? ((3'(min_backoff_exponent) < csmaca_pkg::BLE_BE_CAP) ?
    3'(min_backoff_exponent) : csmaca_pkg::BLE_BE_CAP) : 3'(min_backoff_exponent);
  function automatic logic [5:0] backoff_mask(input logic [2:0] exponent);
    backoff_mask = 6'((7'h01 << exponent) - 7'h01);
  endfunction : backoff_mask

  wire [5:0] draw = rand_value[5:0] & backoff_mask(be_q);
  wire period_edge = slotted ? slot_boundary : timer_done;
  wire [2:0] be_next_raw = be_q + 3'h1;
  wire [2:0] be_cap = ble ? csmaca_pkg::BLE_BE_CAP : csmaca_pkg::MAX_BE;
  wire [2:0] be_next = (be_next_raw > be_cap) ? be_cap : be_next_raw;
  wire [5:0] draw_retry = rand_value[5:0] & backoff_mask(be_next);
  wire attempts_over = nb_q >= max_backoff_count;
  wire ifs_done = !ifs_pending_q || timer_done;
  wire go_direct = tx_request && (tx_direct || no_csma);

  // Unslotted backoff counts its own backoff-period timer; slotted waits for slot edges.
  assign timer_load = (state_q == csmaca_pkg::CSMACA_ST_SEND && tx_end && !tx_ack_request) ||
    (state_q == csmaca_pkg::CSMACA_ST_ACKWAIT && ack_end) ||
    (state_q == csmaca_pkg::CSMACA_ST_BACKOFF && !slotted && !timer_busy && !timer_done);
  assign timer_count = (state_q == csmaca_pkg::CSMACA_ST_BACKOFF) ? BACKOFF_SYMBOLS :
    (long_ifs_q ? long_ifs_symbols : short_ifs_symbols);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      csmaca_pkg::CSMACA_ST_IDLE:
        if (tx_request && !ifs_pending_q)
          state_d = go_direct ? csmaca_pkg::CSMACA_ST_SEND : csmaca_pkg::CSMACA_ST_BACKOFF;
      csmaca_pkg::CSMACA_ST_IFS:
        if (ifs_done)
          state_d = csmaca_pkg::CSMACA_ST_IDLE;
      csmaca_pkg::CSMACA_ST_BACKOFF:
        if (backoff_left_q == 6'h00 && period_edge)
          state_d = csmaca_pkg::CSMACA_ST_CCA;
      csmaca_pkg::CSMACA_ST_CCA:
        if (cca_done)
        begin
          if (cca_clear && (!slotted || cw_q == 2'h1))
            state_d = csmaca_pkg::CSMACA_ST_SEND;
          else if (!cca_clear && attempts_over)
            state_d = csmaca_pkg::CSMACA_ST_IDLE;
          else
            state_d = csmaca_pkg::CSMACA_ST_BACKOFF;
        end
      csmaca_pkg::CSMACA_ST_SEND:
        if (tx_end)
          state_d = tx_ack_request ? csmaca_pkg::CSMACA_ST_ACKWAIT : csmaca_pkg::CSMACA_ST_IFS;
      csmaca_pkg::CSMACA_ST_ACKWAIT:
        if (ack_end)
          state_d = csmaca_pkg::CSMACA_ST_IFS;
      default:
        state_d = csmaca_pkg::CSMACA_ST_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= csmaca_pkg::CSMACA_ST_IDLE;
      be_q <= 3'h0;
      nb_q <= 3'h0;
      cw_q <= 2'h0;
      backoff_left_q <= 6'h00;
      long_ifs_q <= 1'b0;
      ifs_pending_q <= 1'b0;
      fail_count_q <= 3'h0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q == csmaca_pkg::CSMACA_ST_IDLE && tx_request)
      begin
        be_q <= be_start;
        nb_q <= 3'h0;
        cw_q <= csmaca_pkg::SLOTTED_CW;
        long_ifs_q <= tx_length > csmaca_pkg::MAX_SHORT_FRAME_OCTETS;
      end
      if (state_q != csmaca_pkg::CSMACA_ST_BACKOFF && state_d == csmaca_pkg::CSMACA_ST_BACKOFF)
        // A clear first slotted assessment repeats on the very next boundary; a busy one redraws.
        backoff_left_q <= (state_q == csmaca_pkg::CSMACA_ST_CCA) ? (cca_clear ? 6'h00 : draw_retry) : draw;
      else if (state_q == csmaca_pkg::CSMACA_ST_BACKOFF && period_edge && backoff_left_q != 6'h00)
        backoff_left_q <= backoff_left_q - 6'h01;
      if (state_q == csmaca_pkg::CSMACA_ST_CCA && cca_done)
      begin
        if (!cca_clear)
        begin
          nb_q <= nb_q + 3'h1;
          be_q <= be_next;
          cw_q <= csmaca_pkg::SLOTTED_CW;
        end
        else
          cw_q <= cw_q - 2'h1;
      end
      if (state_q == csmaca_pkg::CSMACA_ST_CCA && cca_done && !cca_clear && attempts_over)
        fail_count_q <= fail_count_q + 3'h1;
      if (timer_load && state_q != csmaca_pkg::CSMACA_ST_BACKOFF)
        ifs_pending_q <= 1'b1;
      else if (timer_done && state_q != csmaca_pkg::CSMACA_ST_BACKOFF)
        ifs_pending_q <= 1'b0;
    end
  end

  // Outputs, all registered.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cca_start <= 1'b0;
      tx_start <= 1'b0;
      tx_busy <= 1'b0;
      ack_window <= 1'b0;
      tx_result <= 2'(csmaca_pkg::CSMACA_RES_NONE);
    end
    else
    begin
      cca_start <= state_q == csmaca_pkg::CSMACA_ST_BACKOFF && state_d == csmaca_pkg::CSMACA_ST_CCA;
      tx_start <= state_q != csmaca_pkg::CSMACA_ST_SEND && state_d == csmaca_pkg::CSMACA_ST_SEND;
      tx_busy <= state_d != csmaca_pkg::CSMACA_ST_IDLE;
      ack_window <= state_d == csmaca_pkg::CSMACA_ST_ACKWAIT;
      if (tx_start)
        tx_result <= 2'(csmaca_pkg::CSMACA_RES_SUCCESS);
      else if (state_q == csmaca_pkg::CSMACA_ST_CCA && cca_done && !cca_clear && attempts_over)
        tx_result <= 2'(csmaca_pkg::CSMACA_RES_FAIL);
      else if (state_q == csmaca_pkg::CSMACA_ST_IDLE && tx_request)
        tx_result <= 2'(csmaca_pkg::CSMACA_RES_NONE);
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY.
  // Only whole-word transfers are taken; hsize holds the log2 of the byte count.
  wire bus_take = hsel && hready && htrans[1] && (hsize == 3'(csmaca_pkg::BYTE_SHIFT));
  wire [7:0] rd_idx = haddr[9:2];
  wire [31:0] rd_word = (rd_idx == csmaca_pkg::IDX_ACCESS_CONTROL) ? {24'h000000, access_q} :
    (rd_idx == csmaca_pkg::IDX_LONG_SPACING) ? {24'h000000, long_q} :
    (rd_idx == csmaca_pkg::IDX_TURNAROUND) ? {24'h000000, turn_q[7:4], 4'h0} :
    (rd_idx == csmaca_pkg::IDX_STAB_SHORT) ? {24'h000000, stab_q} :
    (rd_idx == csmaca_pkg::IDX_COMMAND) ? {16'h0000, seed_q} :
    (rd_idx == csmaca_pkg::IDX_STATUS) ? {16'h0000, ifs_pending_q, timer_busy, fail_count_q,
      nb_q, be_q, 5'(state_q)} :
    (rd_idx == csmaca_pkg::IDX_TIMING) ? {8'h00, turnaround_symbols, long_ifs_symbols, short_ifs_symbols} :
    (rd_idx == csmaca_pkg::IDX_RANDOM) ? {16'h0000, rand_value} : 32'h00000000;
  wire wr_hit = wr_pend_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      access_q <= csmaca_pkg::RST_ACCESS_CONTROL;
      long_q <= csmaca_pkg::RST_LONG_SPACING;
      turn_q <= csmaca_pkg::RST_TURNAROUND;
      stab_q <= csmaca_pkg::RST_STAB_SHORT;
      seed_q <= 16'hACE1;
      seed_load_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= bus_take && hwrite;
      wr_idx_q <= haddr[9:2];
      hrdata <= (bus_take && !hwrite) ? rd_word : hrdata;
      seed_load_q <= 1'b0;
      if (wr_hit)
      begin
        case (wr_idx_q)
          csmaca_pkg::IDX_ACCESS_CONTROL:
            access_q <= hwdata[7:0];
          csmaca_pkg::IDX_LONG_SPACING:
            long_q <= hwdata[7:0];
          csmaca_pkg::IDX_TURNAROUND:
            turn_q <= {hwdata[7:4], 4'h0};
          csmaca_pkg::IDX_STAB_SHORT:
            stab_q <= hwdata[7:0];
          csmaca_pkg::IDX_COMMAND:
          begin
            seed_q <= hwdata[15:0];
            seed_load_q <= 1'b1;
          end
          default:
            seed_load_q <= 1'b0;
        endcase
      end
    end
  end

endmodule : csmaca_ifs_timing

/* sim/csmaca_channel_model.sv */
`timescale 1ns/1ps
// Far side: symbol timebase, coordinator slots, channel assessment and frame ends.
module csmaca_channel_model #(
  parameter int TICK = 4
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // From the device and the testbench
  input wire logic cca_start,
  input wire logic tx_start,
  input wire logic ack_req,
  input wire logic channel_busy,
  // To the device
  output logic symbol_tick,
  output logic slot_boundary,
  output logic cca_done,
  output logic cca_clear,
  output logic tx_end,
  output logic ack_end
);
  int sym_q, cca_q, tx_q, ack_q;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sym_q <= 0;
      cca_q <= 0;
      tx_q <= 0;
      ack_q <= 0;
      {symbol_tick, slot_boundary, cca_done, cca_clear, tx_end, ack_end} <= 6'h00;
    end
    else
    begin
      sym_q <= (sym_q == 20 * TICK - 1) ? 0 : sym_q + 1;
      symbol_tick <= (sym_q % TICK) == 0;
      slot_boundary <= sym_q == 0;
      cca_q <= cca_start ? 8 : (cca_q > 0 ? cca_q - 1 : 0);
      cca_done <= cca_q == 1;
      // Between results the clear flag toggles, so sampling it early reads noise.
      cca_clear <= (cca_q == 1) ? !channel_busy : !cca_clear;
      tx_q <= tx_start ? 30 : (tx_q > 0 ? tx_q - 1 : 0);
      tx_end <= tx_q == 1;
      ack_q <= (tx_q == 1 && ack_req) ? 20 : (ack_q > 0 ? ack_q - 1 : 0);
      ack_end <= ack_q == 1;
    end
  end
endmodule : csmaca_channel_model

/* sim/csmaca_ifs_timing_properties.sv */
`timescale 1ns/1ps
module csmaca_ifs_timing_properties (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus response
  input wire logic hreadyout,
  input wire logic hresp,
  // Transmit control
  input wire logic tx_request,
  input wire logic tx_direct,
  input wire logic tx_ack_request,
  input wire logic tx_end,
  input wire logic cca_start,
  input wire logic tx_start,
  input wire logic tx_busy,
  input wire logic ack_window,
  input wire logic [1:0] tx_result
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  a_okay_response: assert property (hresp == 1'b0) else $error("bus response not OKAY");
  a_zero_wait: assert property (hreadyout == 1'b1) else $error("bus wait state inserted");
  a_direct_start: assert property (tx_request && tx_direct && !tx_busy |-> ##1 tx_start)
    else $error("direct frame not started one cycle after request");
  a_direct_no_cca: assert property (tx_request && tx_direct && !tx_busy |-> ##1 !cca_start ##1 !cca_start)
    else $error("direct frame ran channel assessment");
  a_start_pulse: assert property (tx_start |=> !tx_start) else $error("transmit start longer than one cycle");
  a_cca_pulse: assert property (cca_start |=> !cca_start) else $error("assessment start longer than one cycle");
  a_start_busy: assert property (tx_start |-> tx_busy) else $error("transmit start while idle");
  a_ack_wait: assert property (tx_end && tx_ack_request && tx_busy |-> ##[1:2] ack_window)
    else $error("no acknowledgment wait after frame");
  a_ack_quiet: assert property (ack_window |-> tx_busy && !tx_start && !cca_start)
    else $error("activity during acknowledgment wait");
  a_result_code: assert property (tx_result != 2'h3) else $error("undefined result code");
  c_ack_wait: cover property (ack_window);
  c_failure: cover property (tx_result == 2'h2);
  c_direct: cover property (tx_request && tx_direct && !tx_busy);
endmodule : csmaca_ifs_timing_properties

bind csmaca_ifs_timing csmaca_ifs_timing_properties csmaca_ifs_timing_properties_inst (.hclk, .hresetn,
  .hreadyout, .hresp, .tx_request, .tx_direct, .tx_ack_request, .tx_end, .cca_start, .tx_start, .tx_busy,
  .ack_window, .tx_result);

/* sim/test_csma_ca_ifs_timing.sv */
`timescale 1ns/1ps
module test_csma_ca_ifs_timing;
  localparam int TICK = 4;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0] htrans = 0, tx_result;
  logic [6:0] tx_length = 0;
  logic tx_request = 0, tx_direct = 0, tx_ack_request = 0, channel_busy = 0;
  logic hreadyout, hresp, symbol_tick, slot_boundary, cca_clear, cca_done, tx_end, ack_end;
  logic cca_start, tx_start, tx_busy, ack_window;
  int fail_count = 0, comparisons = 0, cyc = 0;
  assign hready = hreadyout;
  always #5 hclk = ~hclk;
  csmaca_ifs_timing csmaca_ifs_timing_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .symbol_tick, .slot_boundary, .cca_clear, .cca_done,
    .tx_request, .tx_direct, .tx_length, .tx_ack_request, .tx_end, .ack_end, .cca_start, .tx_start,
    .tx_busy, .ack_window, .tx_result);
  csmaca_channel_model #(.TICK(TICK)) csmaca_channel_model_inst (.hclk, .hresetn, .cca_start, .tx_start,
    .ack_req(tx_ack_request), .channel_busy, .symbol_tick, .slot_boundary, .cca_done, .cca_clear, .tx_end,
    .ack_end);
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      fail_count++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic check_range(input int got, input int lo, input int hi);
    comparisons++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : check_range
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= 32'(idx) << csmaca_pkg::BYTE_SHIFT;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic reg_check(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    bus(idx, 1'b0, 32'h0, rd);
    check(rd, exp);
  endtask : reg_check
  task automatic reg_write(input logic [7:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    bus(idx, 1'b1, wd, rd);
  endtask : reg_write
  // Sends one frame and follows it until idle; space counts cycles from the frame end, or from the acknowledgment end when one is requested, to idle.
  // Aligned counts assessments started one cycle after a slot boundary reached the device.
  task automatic run_tx(input logic [6:0] len, input logic direct, input logic ack, input logic poke,
                        output int ccas, output int starts, output int space, output logic [1:0] res,
                        output int aligned);
    int n;
    logic seen;
    logic prev_slot;
    aligned = 0;
    prev_slot = 0;
    ccas = 0;
    starts = 0;
    space = 0;
    res = 2'h0;
    n = 0;
    seen = 0;
    @(posedge hclk);
    tx_request <= 1;
    tx_direct <= direct;
    tx_length <= len;
    tx_ack_request <= ack;
    @(posedge hclk);
    tx_request <= 0;
    while (n < 3 || tx_busy !== 1'b0)
    begin
      @(posedge hclk);
      n++;
      tx_request <= poke && seen && space == 3;
      ccas += (cca_start === 1'b1);
      starts += (tx_start === 1'b1);
      aligned += (cca_start === 1'b1 && prev_slot === 1'b1);
      prev_slot = slot_boundary;
      if (tx_result !== 2'h0)
        res = tx_result;
      if (seen)
        space++;
      if (ack ? ack_end === 1'b1 : tx_end === 1'b1)
        seen = 1;
    end
  endtask : run_tx
  task automatic test_registers();
    reg_check(csmaca_pkg::IDX_ACCESS_CONTROL, 32'(csmaca_pkg::RST_ACCESS_CONTROL));
    reg_check(csmaca_pkg::IDX_LONG_SPACING, 32'(csmaca_pkg::RST_LONG_SPACING));
    reg_check(csmaca_pkg::IDX_TURNAROUND, 32'(csmaca_pkg::RST_TURNAROUND));
    reg_check(csmaca_pkg::IDX_STAB_SHORT, 32'(csmaca_pkg::RST_STAB_SHORT));
    reg_check(8'h10, 32'h0);
    reg_write(csmaca_pkg::IDX_ACCESS_CONTROL, 32'h7D);
    reg_check(csmaca_pkg::IDX_ACCESS_CONTROL, 32'h7D);
    // Short spacing 3+2 symbols, long spacing 12+2 symbols.
    reg_write(csmaca_pkg::IDX_STAB_SHORT, 32'h23);
    reg_write(csmaca_pkg::IDX_LONG_SPACING, 32'h30);
    reg_check(csmaca_pkg::IDX_LONG_SPACING, 32'h30);
    // Computed times: turnaround 3+2, long 12+2, short 3+2 symbols.
    reg_check(csmaca_pkg::IDX_TIMING, 32'h00050E05);
  endtask : test_registers
  task automatic test_spacing(input logic [6:0] len, input logic ack, input int sym);
    int c, s, sp, a;
    logic [1:0] r;
    run_tx(len, 1'b1, ack, 1'b1, c, s, sp, r, a);
    check(32'(c), 32'h0);
    check(32'(s), 32'h1);
    check_range(sp, (sym - 1) * TICK, (sym + 1) * TICK + 4);
  endtask : test_spacing
  task automatic test_csma(input logic [7:0] access, input logic busy, input int exp_cca, input logic [1:0] exp_res);
    int c, s, sp, a;
    logic [1:0] r;
    reg_write(csmaca_pkg::IDX_ACCESS_CONTROL, 32'(access));
    channel_busy <= busy;
    run_tx(7'h0A, 1'b0, 1'b0, 1'b0, c, s, sp, r, a);
    check(32'(c), 32'(exp_cca));
    check(32'(s), 32'(!busy));
    check(32'(r), 32'(exp_res));
    if (access[csmaca_pkg::F_SLOTTED])
      check(32'(a), 32'(exp_cca));
  endtask : test_csma
  // Minimum exponent 3 with battery extension must start the backoff at the capped exponent.
  task automatic test_ble();
    logic [31:0] st;
    test_csma(8'h79, 1'b0, 2, csmaca_pkg::CSMACA_RES_SUCCESS);
    bus(csmaca_pkg::IDX_STATUS, 1'b0, 32'h0, st);
    check(32'(st[7:5]), 32'(csmaca_pkg::BLE_BE_CAP));
  endtask : test_ble
  initial
  begin
    repeat (3) @(posedge hclk);
    hresetn <= 1;
    test_registers();
    test_spacing(7'h12, 1'b0, 5);
    test_spacing(7'h13, 1'b0, 14);
    test_spacing(7'h0A, 1'b1, 5);
    // A nonbeacon host keeps the slotted bit clear, so no superframe timing applies.
    test_csma(8'h09, 1'b0, 1, csmaca_pkg::CSMACA_RES_SUCCESS);
    for (int b = 0; b < 3; b++)
      test_csma(8'h08 + 8'(b), 1'b1, b + 1, csmaca_pkg::CSMACA_RES_FAIL);
    test_csma(8'h29, 1'b0, 2, csmaca_pkg::CSMACA_RES_SUCCESS);
    test_csma(8'h69, 1'b0, 2, csmaca_pkg::CSMACA_RES_SUCCESS);
    test_ble();
    wrap_up();
  end
endmodule : test_csma_ca_ifs_timing
